// [psm_cpu_model.sv]
// cpu model issuing instruction steps and wake requests
`timescale 1ns/1ps
module psm_cpu_model (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic bvalid_i,
  input wire logic bready_i,
  input wire logic extra_i,
  input wire logic wake_i,
  output logic instr_step_o,
  output logic wake_irq_o
);
  // one step per register write, extra steps on request
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      instr_step_o <= 1'b0;
      wake_irq_o <= 1'b0;
    end else begin
      instr_step_o <= (bvalid_i && bready_i) || extra_i;
      wake_irq_o <= wake_i;
    end
  end
endmodule // psm_cpu_model

// [psm_ctrl.v]
// power-saving mode controller with axi4-lite registers
`timescale 1ns/1ps
`include "psm_defs.vh"
module psm_ctrl #(
  parameter ADDR_W = 12,
  parameter IO_W = 40
) (
  input wire ref_clk_i,
  input wire reset_n_i,
  // axi4-lite slave
  input wire [ADDR_W-1:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [ADDR_W-1:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // core side
  input wire instr_step_i,
  input wire wake_irq_i,
  input wire ext_fetch_i,
  input wire ale_run_i,
  input wire program_store_strobe_run_i,
  input wire [7:0] p0_run_i,
  input wire p0_oe_n_run_i,
  input wire [7:0] p2_run_i,
  input wire [7:0] p2_latch_i,
  input wire [IO_W-1:0] io_run_i,
  // pins
  input wire save_block_pin_i,
  output reg ale_o,
  output reg program_store_strobe_o,
  output reg [7:0] p0_o,
  output reg p0_oe_n_o,
  output reg [7:0] p2_o,
  output reg [IO_W-1:0] io_o,
  // clock control
  output reg cpu_clk_en_o,
  output reg periph_clk_en_o,
  output reg osc_run_o,
  output reg wdt_autostart_o
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_PD = 2'h2;

  reg [1:0] state_reg;
  reg [1:0] state_next;

  // ----------------------------------------------------------------
  // blocking pin synchroniser and strap capture
  // ----------------------------------------------------------------
  reg block_meta_reg;
  reg block_sync_reg;
  reg [1:0] strap_cnt_reg;

  // pullup default keeps modes blocked until the pin is seen
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      block_meta_reg <= `PSM_BLOCK_RST;
      block_sync_reg <= `PSM_BLOCK_RST;
    end else begin
      block_meta_reg <= save_block_pin_i;
      block_sync_reg <= block_meta_reg;
    end
  end

  // pin level caught once after release, never again
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_cnt_reg <= 2'h0;
      wdt_autostart_o <= 1'b0;
    end else if (strap_cnt_reg != `PSM_STRAP_WAIT) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == `PSM_STRAP_WAIT - 2'h1) begin
        wdt_autostart_o <= block_sync_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  reg aw_full_reg;
  reg w_full_reg;
  reg [ADDR_W-1:0] awaddr_reg;
  reg [7:0] wbyte_reg;
  reg wlane_reg;
  wire wr_fire;
  wire wr_hit_power_mode_control;
  wire wr_hit_stat;
  wire power_mode_control_wr;

  assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid_o;
  assign wr_hit_power_mode_control = {awaddr_reg[ADDR_W-1:2], 2'b00} == `PSM_POWER_MODE_CONTROL_ADDR;
  assign wr_hit_stat = {awaddr_reg[ADDR_W-1:2], 2'b00} == `PSM_STAT_ADDR;
  assign power_mode_control_wr = wr_fire && wr_hit_power_mode_control && wlane_reg;

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= {ADDR_W{1'b0}};
      wbyte_reg <= 8'h00;
      wlane_reg <= 1'b0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `PSM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full_reg <= 1'b1;
        wbyte_reg <= s_axi_wdata_i[7:0];
        wlane_reg <= s_axi_wstrb_i[0];
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid_o <= 1'b1;
        if (wr_hit_power_mode_control || wr_hit_stat) begin
          s_axi_bresp_o <= `PSM_RESP_OKAY;
        end else begin
          s_axi_bresp_o <= `PSM_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // power_mode_control and entry sequences
  // ----------------------------------------------------------------
  reg slow_reg;
  reg sleep_arm_reg;
  reg pd_arm_reg;
  reg sleep_go_reg;
  reg pd_go_reg;
  reg arm_age_reg;
  reg ext_reg;
  wire slow_active;
  wire arm_wr;
  wire sleep_arm_wr;
  wire pd_arm_wr;
  wire sleep_go_wr;
  wire pd_go_wr;

  // slow-down follows the pin live
  assign slow_active = slow_reg && !block_sync_reg;
  assign sleep_arm_wr = power_mode_control_wr && wbyte_reg[`PSM_SLEEP_ARM]
    && !wbyte_reg[`PSM_SLEEP_GO];
  assign pd_arm_wr = power_mode_control_wr && wbyte_reg[`PSM_PD_ARM]
    && !wbyte_reg[`PSM_PD_GO];
  assign arm_wr = sleep_arm_wr || pd_arm_wr;
  assign sleep_go_wr = power_mode_control_wr && wbyte_reg[`PSM_SLEEP_GO] && sleep_arm_reg;
  assign pd_go_wr = power_mode_control_wr && wbyte_reg[`PSM_PD_GO] && pd_arm_reg;

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slow_reg <= |(`PSM_POWER_MODE_CONTROL_RST & (8'h01 << `PSM_SLOW));
      sleep_arm_reg <= 1'b0;
      pd_arm_reg <= 1'b0;
      sleep_go_reg <= 1'b0;
      pd_go_reg <= 1'b0;
      arm_age_reg <= 1'b0;
    end else begin
      // go flags last one cycle only
      sleep_go_reg <= 1'b0;
      pd_go_reg <= 1'b0;
      if (power_mode_control_wr) begin
        slow_reg <= wbyte_reg[`PSM_SLOW];
      end
      if (block_sync_reg) begin
        sleep_arm_reg <= 1'b0;
        pd_arm_reg <= 1'b0;
      end else if (power_mode_control_wr) begin
        // any other write between arm and go spoils the arm
        sleep_arm_reg <= sleep_arm_wr;
        pd_arm_reg <= pd_arm_wr;
        sleep_go_reg <= sleep_go_wr;
        pd_go_reg <= pd_go_wr;
        arm_age_reg <= 1'b0;
      end else if (instr_step_i) begin
        // arm outlives its own instruction and no more
        if (arm_age_reg) begin
          sleep_arm_reg <= 1'b0;
          pd_arm_reg <= 1'b0;
        end
        arm_age_reg <= sleep_arm_reg || pd_arm_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------
  always @* begin
    case (state_reg)
      ST_RUN: begin
        if (block_sync_reg) begin
          state_next = ST_RUN;
        end else if (pd_go_wr) begin
          state_next = ST_PD;
        end else if (sleep_go_wr) begin
          state_next = ST_IDLE;
        end else begin
          state_next = ST_RUN;
        end
      end
      ST_IDLE: begin
        if (wake_irq_i) begin
          state_next = ST_RUN;
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_PD: begin
        state_next = ST_PD;
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // reset ends any mode; oscillator never stops in idle
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_RUN;
      ext_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_RUN) begin
        ext_reg <= ext_fetch_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // clock gating
  // ----------------------------------------------------------------
  wire tick;

  psm_slow_div #(
    .DIV(`PSM_SLOW_DIV)
  ) u_slow_div (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .slow_i(slow_active),
    .tick_o(tick)
  );

  // cpu stops after the go write; peripherals keep going in idle
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cpu_clk_en_o <= 1'b1;
      periph_clk_en_o <= 1'b1;
      osc_run_o <= 1'b1;
    end else begin
      cpu_clk_en_o <= tick && state_next == ST_RUN;
      periph_clk_en_o <= tick && state_next != ST_PD;
      osc_run_o <= state_next != ST_PD;
    end
  end

  // ----------------------------------------------------------------
  // pin behaviour per mode
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ale_o <= 1'b1;
      program_store_strobe_o <= 1'b1;
      p0_o <= 8'hff;
      p0_oe_n_o <= 1'b1;
      p2_o <= 8'hff;
      io_o <= {IO_W{1'b1}};
    end else begin
      case (state_next)
        ST_IDLE: begin
          ale_o <= 1'b1;
          program_store_strobe_o <= 1'b1;
          if (ext_reg) begin
            p0_oe_n_o <= 1'b1;
          end else begin
            p2_o <= p2_latch_i;
          end
          io_o <= io_run_i;
        end
        ST_PD: begin
          ale_o <= 1'b0;
          program_store_strobe_o <= 1'b0;
          p0_oe_n_o <= p0_oe_n_o | ext_reg;
          p2_o <= p2_latch_i;
          io_o <= io_o;
        end
        default: begin
          ale_o <= ale_run_i;
          program_store_strobe_o <= program_store_strobe_run_i;
          p0_o <= p0_run_i;
          p0_oe_n_o <= p0_oe_n_run_i;
          p2_o <= p2_run_i;
          io_o <= io_run_i;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  reg [31:0] rd_data;
  reg [1:0] rd_resp;
  wire [7:0] power_mode_control_view;
  wire [7:0] stat_view;

  assign power_mode_control_view = {1'b0, pd_go_reg, sleep_go_reg, slow_reg, 2'h0,
    pd_arm_reg, sleep_arm_reg};
  assign stat_view = {3'h0, wdt_autostart_o, block_sync_reg, slow_active,
    state_reg == ST_PD, state_reg == ST_IDLE};

  always @* begin
    rd_data = 32'h00000000;
    rd_resp = `PSM_RESP_OKAY;
    if ({s_axi_araddr_i[ADDR_W-1:2], 2'b00} == `PSM_POWER_MODE_CONTROL_ADDR) begin
      rd_data = {24'h000000, power_mode_control_view};
    end else if ({s_axi_araddr_i[ADDR_W-1:2], 2'b00} == `PSM_STAT_ADDR) begin
      rd_data = {24'h000000, stat_view};
    end else begin
      rd_resp = `PSM_RESP_SLVERR;
    end
  end

  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `PSM_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rd_data;
        s_axi_rresp_o <= rd_resp;
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end
endmodule // psm_ctrl

// [psm_defs.vh]
// constants of the power-saving mode controller
`ifndef PSM_DEFS_VH
`define PSM_DEFS_VH
// Function
// - slow-down runs whole clock at one eighth
// - idle stops cpu clock, peripherals keep running
// - power-down halts all, stops oscillator, keeps ram
// - mode selected through power_mode_control register
// - blocking pin high ignores every entry sequence
// - blocking pin low allows every mode
// - blocking pin changes live, watchdog untouched
// - power-down needs arm then go, consecutive
// - arm and go bits clear themselves
// - power-down left only by hardware reset
// - idle needs arm then go, consecutive
// - enabled interrupt ends idle, resumes after go
// - reset ends idle, two machine cycles suffice
// - strobes high in idle, low in power-down
// - port 0 and 2 per fetch source
// - idle keeps pins and alternate functions
// - power-down holds ports 1, 3 to 6
// - blocking pin high at reset starts watchdog

// register indices and byte addresses
`define PSM_POWER_MODE_CONTROL_IDX 12'h087
`define PSM_POWER_MODE_CONTROL_ADDR 12'h21c
`define PSM_STAT_ADDR 12'h220

// power_mode_control fields
`define PSM_SLEEP_ARM 0
`define PSM_PD_ARM 1
`define PSM_SLOW 4
`define PSM_SLEEP_GO 5
`define PSM_PD_GO 6

// status fields
`define PSM_ST_IDLE 0
`define PSM_ST_PD 1
`define PSM_ST_SLOW 2
`define PSM_ST_BLOCK 3
`define PSM_ST_WDT 4

// reset values
`define PSM_POWER_MODE_CONTROL_RST 8'h00
`define PSM_BLOCK_RST 1'b1
`define PSM_REG_W 8

// timing counts
`define PSM_SLOW_DIV 8
`define PSM_STRAP_WAIT 2'h3
`define PSM_MACH_CYC 12

// bus answers
`define PSM_RESP_OKAY 2'h0
`define PSM_RESP_SLVERR 2'h2
`endif

// [psm_props.sv]
// checker for the power-saving mode controller
`timescale 1ns/1ps
module psm_props (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic wake_irq_i,
  input wire logic save_block_pin_i,
  input wire logic ale_o,
  input wire logic program_store_strobe_o,
  input wire logic cpu_clk_en_o,
  input wire logic periph_clk_en_o,
  input wire logic osc_run_o,
  input wire logic wdt_autostart_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic [2:0] up_cnt;
  wire idle_w = !cpu_clk_en_o && periph_clk_en_o && osc_run_o;
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) up_cnt <= 3'h0;
    else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
  end
  property p_idle_strb; idle_w |-> ale_o && program_store_strobe_o;
  endproperty
  a_idle_strb: assert property (p_idle_strb) else $error("idle strobe");
  property p_pd_strb; !osc_run_o |-> !ale_o && !program_store_strobe_o;
  endproperty
  a_pd_strb: assert property (p_pd_strb) else $error("pd strobe");
  property p_pd_clk; !osc_run_o |-> !cpu_clk_en_o && !periph_clk_en_o;
  endproperty
  a_pd_clk: assert property (p_pd_clk) else $error("pd clocks");
  property p_pd_stay; !osc_run_o |=> !osc_run_o; endproperty
  a_pd_stay: assert property (p_pd_stay) else $error("pd left");
  property p_wake; idle_w && wake_irq_i |-> ##[1:8] cpu_clk_en_o;
  endproperty
  a_wake: assert property (p_wake) else $error("idle not ended");
  property p_block;
    save_block_pin_i [*6] ##0 (cpu_clk_en_o && osc_run_o) |=> cpu_clk_en_o;
  endproperty
  a_block: assert property (p_block) else $error("mode not blocked");
  property p_slow; !periph_clk_en_o [*7] |=> periph_clk_en_o || !osc_run_o;
  endproperty
  a_slow: assert property (p_slow) else $error("slow gap");
  property p_wdt; up_cnt == 3'h7 |-> $stable(wdt_autostart_o); endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog start moved");
  property p_bresp; s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##2 s_axi_bvalid_o; endproperty
  a_bresp: assert property (p_bresp) else $error("late write answer");
  property p_rresp; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_rresp: assert property (p_rresp) else $error("late read answer");
  c_idle: cover property (idle_w);
  c_pd: cover property (!osc_run_o);
  c_slow: cover property (!periph_clk_en_o && osc_run_o);
endmodule // psm_props

bind psm_ctrl psm_props u_props (.ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .wake_irq_i(wake_irq_i),
  .save_block_pin_i(save_block_pin_i), .ale_o(ale_o),
  .program_store_strobe_o(program_store_strobe_o),
  .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
  .osc_run_o(osc_run_o), .wdt_autostart_o(wdt_autostart_o));

// [psm_slow_div.v]
// clock-enable divider for slow-down operation
`timescale 1ns/1ps
`include "psm_defs.vh"
module psm_slow_div #(
  parameter DIV = `PSM_SLOW_DIV
) (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire slow_i,
  output reg tick_o
);
  reg [3:0] cnt_reg;
  reg [3:0] cnt_next;

  always @* begin
    cnt_next = cnt_reg + 4'h1;
    if (!slow_i || cnt_reg == DIV[3:0] - 4'h1) begin
      cnt_next = 4'h0;
    end
  end

  // one enable in DIV cycles while slow, else every cycle
  always @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= 4'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      tick_o <= !slow_i || cnt_next == 4'h0;
    end
  end
endmodule // psm_slow_div

// [psm_tb.sv]
// testbench of the power-saving mode controller
`timescale 1ns/1ps
module testbench;
  logic clk, rst_n, awv, wv, bready, arv, rready, ext, ale_r, pss_r, oe_r;
  logic pin, extra, wake, aw_rdy, w_rdy, bv, ar_rdy, rv, step_w, irq_w;
  logic ale, pss, oe_n, cpu_en, per_en, osc, wdt;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] p0r, p2r, p2l, p0, p2;
  logic [39:0] io_r, io;
  int n_errors, num_checks, cyc, n;
  psm_ctrl uut (.ref_clk_i(clk), .reset_n_i(rst_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(aw_rdy),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(w_rdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rready), .instr_step_i(step_w),
    .wake_irq_i(irq_w), .ext_fetch_i(ext), .ale_run_i(ale_r),
    .program_store_strobe_run_i(pss_r), .p0_run_i(p0r), .p0_oe_n_run_i(oe_r),
    .p2_run_i(p2r), .p2_latch_i(p2l), .io_run_i(io_r),
    .save_block_pin_i(pin), .ale_o(ale), .program_store_strobe_o(pss),
    .p0_o(p0), .p0_oe_n_o(oe_n), .p2_o(p2), .io_o(io), .cpu_clk_en_o(cpu_en),
    .periph_clk_en_o(per_en), .osc_run_o(osc), .wdt_autostart_o(wdt));
  psm_cpu_model cpu (.ref_clk_i(clk), .reset_n_i(rst_n), .bvalid_i(bv),
    .bready_i(bready), .extra_i(extra), .wake_i(wake),
    .instr_step_o(step_w), .wake_irq_o(irq_w));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input [39:0] g, input [39:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wrc(input [11:0] a, input [7:0] d, input [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    bready <= 1;
    fork
      begin
        do @(posedge clk); while (!aw_rdy);
        awv <= 0;
      end
      begin
        do @(posedge clk); while (!w_rdy);
        wv <= 0;
      end
    join
    while (!bv) @(posedge clk);
    chk(bresp, er);
    bready <= 0;
  endtask
  task automatic rdc(input [11:0] a, input [31:0] e, input [1:0] er);
    @(posedge clk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    do @(posedge clk); while (!ar_rdy);
    arv <= 0;
    while (!rv) @(posedge clk);
    chk(rdata, e);
    chk(rresp, er);
    rready <= 0;
  endtask
  task automatic note(input string s);
    $display("test done: %s", s);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst_n, awv, wv, bready, arv, rready, extra, wake} = 0;
    {awaddr, araddr, wdata, ale_r, pss_r, oe_r} = 0;
    {n_errors, num_checks} = 0;
    pin = 1;
    ext = 1;
    p0r = 8'h5a;
    p2r = 8'ha5;
    p2l = 8'h3c;
    io_r = 0;
    step(20);
    rst_n <= 1;
    rdc(12'h21c, 32'h00, 2'h0);
    rdc(12'h220, 32'h18, 2'h0);
    chk(wdt, 1);
    rdc(12'h300, 32'h00, 2'h2);
    wrc(12'h300, 8'hff, 2'h2);
    note("reset and map");
    wrc(12'h21c, 8'h01, 2'h0);
    wrc(12'h21c, 8'h20, 2'h0);
    step(4);
    chk(cpu_en, 1);
    rdc(12'h220, 32'h18, 2'h0);
    pin <= 0;
    step(6);
    rdc(12'h220, 32'h10, 2'h0);
    note("blocking pin");
    wrc(12'h21c, 8'h01, 2'h0);
    wrc(12'h21c, 8'h20, 2'h0);
    io_r <= 40'h123456789a;
    step(3);
    chk(cpu_en, 0);
    chk(per_en, 1);
    chk({ale, pss}, 2'h3);
    chk(oe_n, 1);
    chk(p2, 8'ha5);
    chk(io, 40'h123456789a);
    rdc(12'h220, 32'h11, 2'h0);
    wake <= 1;
    step(4);
    chk(cpu_en, 1);
    wake <= 0;
    rdc(12'h220, 32'h10, 2'h0);
    note("idle and wake");
    wrc(12'h21c, 8'h01, 2'h0);
    extra <= 1;
    step(1);
    extra <= 0;
    wrc(12'h21c, 8'h20, 2'h0);
    rdc(12'h220, 32'h10, 2'h0);
    wrc(12'h21c, 8'h21, 2'h0);
    rdc(12'h220, 32'h10, 2'h0);
    note("discarded arm");
    wrc(12'h21c, 8'h10, 2'h0);
    step(4);
    n = 0;
    repeat (64) begin
      @(posedge clk);
      n += per_en;
    end
    chk(n, 8);
    rdc(12'h220, 32'h14, 2'h0);
    rdc(12'h21c, 32'h10, 2'h0);
    pin <= 1;
    step(6);
    rdc(12'h220, 32'h18, 2'h0);
    wrc(12'h21c, 8'h00, 2'h0);
    pin <= 0;
    note("slow-down");
    wrc(12'h21c, 8'h01, 2'h0);
    wrc(12'h21c, 8'h20, 2'h0);
    step(3);
    rst_n <= 0;
    step(24);
    rst_n <= 1;
    step(4);
    chk(cpu_en, 1);
    chk(wdt, 0);
    rdc(12'h220, 32'h00, 2'h0);
    note("idle reset");
    ext <= 0;
    ale_r <= 1;
    pss_r <= 1;
    wrc(12'h21c, 8'h02, 2'h0);
    rdc(12'h21c, 32'h02, 2'h0);
    wrc(12'h21c, 8'h40, 2'h0);
    step(3);
    chk({osc, cpu_en, per_en}, 3'h0);
    chk({ale, pss}, 2'h0);
    chk({oe_n, p0, p2}, 17'h05a3c);
    io_r <= 40'h0;
    wake <= 1;
    step(4);
    chk(io, 40'h123456789a);
    chk(osc, 0);
    rdc(12'h21c, 32'h00, 2'h0);
    rdc(12'h220, 32'h02, 2'h0);
    rst_n <= 0;
    wake <= 0;
    step(2);
    rst_n <= 1;
    step(2);
    chk(osc, 1);
    note("power-down");
    wrc(12'h21c, 8'h01, 2'h0);
    wrc(12'h21c, 8'h20, 2'h0);
    step(3);
    chk(cpu_en, 0);
    chk({oe_n, p0, p2}, 17'h05a3c);
    note("idle internal fetch");
    tally_and_finish;
  end
endmodule // testbench
